// file: design/cta_consts.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the tx abort/ident block and its package users
`ifndef CTA_CONSTS_SVH
`define CTA_CONSTS_SVH
`define CTA_NBUF 3
`define CTA_OFF_TARQ 8'h08
`define CTA_OFF_TIER 8'h0c
`define CTA_OFF_CTRL 8'h10
`define CTA_OFF_TFLG 8'h14
`define CTA_OFF_TAAK 8'h18
`define CTA_OFF_IDENT_REG_TWO_EXT 8'h1c
`define CTA_OFF_IDRX 8'h20
`define CTA_OFF_IRQS 8'h24
`define CTA_OFF_IRQC 8'h28
`define CTA_OFF_IRQE 8'h2c
`define CTA_OFF_SEND 8'h30
`define CTA_RST_TARQ 3'h0
`define CTA_RST_TIER 3'h0
`define CTA_RST_TFLG 3'h7
`define CTA_CTRL_INIT_REQUEST 0
`define CTA_ID_W 29
`define CTA_IDENT_REG_TWO_EXT_LSB 7
`define CTA_BIT_TIME_NS 2000
`define CTA_BIT_CYC ((`CTA_BIT_TIME_NS) / 5)
`define CTA_INIT_ACK_CYC 4
`endif

// file: design/cta_pkg.sv
// types shared by the tx abort/ident block
// assumes cta_consts.svh is reachable on the include path
package cta_pkg;
    typedef enum logic [1:0] {
        CTA_IDLE = 2'b00,
        CTA_ARB = 2'b01,
        CTA_DATA = 2'b11
    } cta_tx_e;
    typedef logic [2:0] cta_buf_t;
endpackage

// file: design/cta_arb_shift.sv
// serialises a 29-bit extended identifier msb first with bitwise arbitration
// assumes bit_en is a one-cycle pulse per bus bit; rx_bit is synchronised
`timescale 1ns/1ps
`default_nettype none
module cta_arb_shift #(
    parameter int ID_W = 29
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low active
    input wire logic start, // load identifier
    input wire logic [ID_W-1:0] id_in, // identifier to send
    input wire logic bit_en, // bit time tick
    input wire logic rx_bit, // sampled bus level
    output logic tx_bit, // driven bit, recessive 1
    output logic busy, // arbitration in progress
    output logic lost, // pulse, arbitration lost
    output logic won // pulse, all bits sent
);
    logic [ID_W-1:0] sh_q;
    logic [5:0] cnt_q;
    logic busy_q;
    assign busy = busy_q;
    assign tx_bit = busy_q ? sh_q[ID_W-1] : 1'b1;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_q <= '0;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            lost <= 1'b0;
            won <= 1'b0;
        end else begin
            lost <= 1'b0;
            won <= 1'b0;
            if (start) begin
                sh_q <= id_in;
                cnt_q <= 6'(ID_W);
                busy_q <= 1'b1;
            end else if (busy_q && bit_en) begin
                // recessive sent but dominant seen: smaller id wins
                if (sh_q[ID_W-1] && !rx_bit) begin
                    busy_q <= 1'b0;
                    lost <= 1'b1;
                end else if (cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                    won <= 1'b1;
                end else begin
                    sh_q <= {sh_q[ID_W-2:0], 1'b0};
                    cnt_q <= cnt_q - 6'h01;
                end
            end
        end
    end
endmodule // cta_arb_shift
`default_nettype wire

// file: design/cta_tx_abort.sv
// transmit abort, tx-empty interrupt and extended id arbitration slice
// assumes AXI4-Lite master on aclk; can_rx is asynchronous pin input
`timescale 1ns/1ps
`default_nettype none
`include "cta_consts.svh"
module cta_tx_abort import cta_pkg::*; #(
    parameter int NBUF = `CTA_NBUF,
    parameter int BIT_CYC = `CTA_BIT_CYC
) (
    input wire logic aclk, // clock 200 MHz
    input wire logic aresetn, // sync reset, low active
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic can_rx, // bus receive pin
    output logic can_tx, // bus transmit pin
    output logic irq // level interrupt
);
    logic [2:0] tarq_q, tier_q, tflg_q, taak_q, irqs_q, irqe_q;
    logic init_request_q, init_acknowledge_q;
    logic [2:0] iack_cnt_q;
    logic [`CTA_ID_W-1:0] id_q [NBUF];
    logic [31:0] rdata_q;
    logic aw_q, w_q, bv_q, rv_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_go, wr_ok;
    logic init_mode, init_free;
    logic rx_m_q, rx_s_q;
    logic [15:0] div_q;
    logic bit_en;
    cta_tx_e st_q;
    logic [1:0] cur_q;
    logic send_q;
    logic arb_start, arb_busy, arb_lost, arb_won, arb_tx;
    logic [5:0] data_cnt_q;
    logic [2:0] set_empty, grant, done_ok;
    logic [2:0] eligible;
    logic [1:0] pick;

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !w_q && !bv_q;
    assign wr_go = aw_q && w_q && !bv_q;
    assign wr_ok = wr_go && ws_q[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            bresp_q <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bv_q <= 1'b1;
                unique case (awa_q)
                    `CTA_OFF_TARQ, `CTA_OFF_TIER, `CTA_OFF_CTRL, `CTA_OFF_IDENT_REG_TWO_EXT,
                    `CTA_OFF_IDRX, `CTA_OFF_IRQC, `CTA_OFF_IRQE, `CTA_OFF_SEND,
                    `CTA_OFF_TFLG, `CTA_OFF_TAAK, `CTA_OFF_IRQS: bresp_q <= 2'h0;
                    default: bresp_q <= 2'h2;
                endcase
            end else if (bv_q && s_axi_bready) begin
                bv_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;

    // init mode handshake: acknowledge follows request after a short delay
    assign init_mode = init_request_q && init_acknowledge_q;
    assign init_free = !init_request_q && !init_acknowledge_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_request_q <= 1'b0;
        end else if (wr_ok && awa_q == `CTA_OFF_CTRL) begin
            init_request_q <= wd_q[`CTA_CTRL_INIT_REQUEST];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_acknowledge_q <= 1'b0;
            iack_cnt_q <= 3'h0;
        end else if (init_request_q != init_acknowledge_q && st_q == CTA_IDLE) begin
            if (iack_cnt_q == 3'(`CTA_INIT_ACK_CYC - 1)) begin
                init_acknowledge_q <= init_request_q;
                iack_cnt_q <= 3'h0;
            end else begin
                iack_cnt_q <= iack_cnt_q + 3'h1;
            end
        end else begin
            iack_cnt_q <= 3'h0;
        end
    end

    // empty interrupt enables
    always_ff @(posedge aclk) begin
        if (!aresetn || init_mode) begin
            tier_q <= `CTA_RST_TIER;
        end else if (wr_ok && awa_q == `CTA_OFF_TIER && init_free) begin
            tier_q <= wd_q[2:0];
        end
    end

    // abort requests: write 1 sets, only empty flag or init mode clears
    always_ff @(posedge aclk) begin
        if (!aresetn || init_mode) begin
            tarq_q <= `CTA_RST_TARQ;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (set_empty[i]) begin
                    tarq_q[i] <= 1'b0;
                end else if (wr_ok && awa_q == `CTA_OFF_TARQ && init_free
                             && wd_q[i] && !tflg_q[i]) begin
                    tarq_q[i] <= 1'b1;
                end
            end
        end
    end

    // pin synchroniser and bit timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else begin
            rx_m_q <= can_rx;
            rx_s_q <= rx_m_q;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || bit_en) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end
    assign bit_en = (div_q == 16'(BIT_CYC - 1));

    // buffer selection: lowest identifier among queued buffers
    always_comb begin
        eligible = ~tflg_q & ~tarq_q;
        pick = 2'd0;
        for (int i = 2; i >= 0; i--) begin
            if (eligible[i] && (!eligible[pick] || id_q[i] <= id_q[pick])) begin
                pick = 2'(i);
            end
        end
    end
    assign arb_start = st_q == CTA_IDLE && send_q && !init_request_q && |eligible && bit_en;

    cta_arb_shift #(
        .ID_W(`CTA_ID_W)
    ) u_arb (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(arb_start),
        .id_in(id_q[pick]),
        .bit_en(bit_en),
        .rx_bit(rx_s_q),
        .tx_bit(arb_tx),
        .busy(arb_busy),
        .lost(arb_lost),
        .won(arb_won)
    );
    assign can_tx = arb_tx;

    // transmit sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= CTA_IDLE;
            cur_q <= 2'd0;
            data_cnt_q <= 6'h00;
        end else begin
            unique case (st_q)
                CTA_IDLE: begin
                    if (arb_start) begin
                        st_q <= CTA_ARB;
                        cur_q <= pick;
                    end
                end
                CTA_ARB: begin
                    if (arb_lost) begin
                        st_q <= CTA_IDLE;
                    end else if (arb_won) begin
                        st_q <= CTA_DATA;
                        data_cnt_q <= 6'h08;
                    end
                end
                CTA_DATA: begin
                    if (bit_en) begin
                        if (data_cnt_q == 6'h01) begin
                            st_q <= CTA_IDLE;
                        end
                        data_cnt_q <= data_cnt_q - 6'h01;
                    end
                end
                default: st_q <= CTA_IDLE;
            endcase
        end
    end

    // grants and completions
    always_comb begin
        grant = 3'h0;
        done_ok = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (tarq_q[i] && !tflg_q[i]
                && (st_q == CTA_IDLE || cur_q != 2'(i) || arb_lost)) begin
                grant[i] = 1'b1;
            end
        end
        if (st_q == CTA_DATA && bit_en && data_cnt_q == 6'h01) begin
            done_ok[cur_q] = 1'b1;
            grant[cur_q] = 1'b0;
        end
    end
    assign set_empty = grant | done_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tflg_q <= `CTA_RST_TFLG;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (set_empty[i]) begin
                    tflg_q[i] <= 1'b1;
                end else if (wr_ok && awa_q == `CTA_OFF_TFLG && wd_q[i]) begin
                    tflg_q[i] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taak_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (grant[i]) begin
                    taak_q[i] <= 1'b1;
                end else if (wr_ok && awa_q == `CTA_OFF_TFLG && wd_q[i]) begin
                    taak_q[i] <= 1'b0;
                end
            end
        end
    end

    // identifier storage; ident reg two maps id[14:7]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NBUF; i++) begin
                id_q[i] <= '0;
            end
        end else if (wr_ok && awa_q == `CTA_OFF_IDENT_REG_TWO_EXT) begin
            id_q[wd_q[9:8]][`CTA_IDENT_REG_TWO_EXT_LSB +: 8] <= wd_q[7:0];
        end else if (wr_ok && awa_q == `CTA_OFF_IDRX) begin
            id_q[wd_q[31:30]] <= wd_q[`CTA_ID_W-1:0];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            send_q <= 1'b0;
        end else if (wr_ok && awa_q == `CTA_OFF_SEND) begin
            send_q <= wd_q[0];
        end
    end

    // interrupt status: set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irqs_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (set_empty[i] && tier_q[i]) begin
                    irqs_q[i] <= 1'b1;
                end else if (wr_ok && awa_q == `CTA_OFF_IRQC && wd_q[i]) begin
                    irqs_q[i] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irqe_q <= 3'h0;
        end else if (wr_ok && awa_q == `CTA_OFF_IRQE) begin
            irqe_q <= wd_q[2:0];
        end
    end
    assign irq = |(irqs_q & irqe_q);

    // read channel
    assign s_axi_arready = !rv_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rv_q <= 1'b1;
            rresp_q <= 2'h0;
            unique case (s_axi_araddr)
                `CTA_OFF_TARQ: rdata_q <= {29'h0, tarq_q};
                `CTA_OFF_TIER: rdata_q <= {29'h0, tier_q};
                `CTA_OFF_CTRL: rdata_q <= {30'h0, init_acknowledge_q, init_request_q};
                `CTA_OFF_TFLG: rdata_q <= {29'h0, tflg_q};
                `CTA_OFF_TAAK: rdata_q <= {29'h0, taak_q};
                `CTA_OFF_IDENT_REG_TWO_EXT: rdata_q <= {24'h0, id_q[0][`CTA_IDENT_REG_TWO_EXT_LSB +: 8]};
                `CTA_OFF_IDRX: rdata_q <= {3'h0, id_q[0]};
                `CTA_OFF_IRQS: rdata_q <= {29'h0, irqs_q};
                `CTA_OFF_IRQE: rdata_q <= {29'h0, irqe_q};
                `CTA_OFF_SEND: rdata_q <= {31'h0, send_q};
                `CTA_OFF_IRQC: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'h2;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    a_tier_init_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        init_mode |=> tier_q == `CTA_RST_TIER)
        else $error("enable register changed in init mode");
    a_tarq_init_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        init_mode |=> tarq_q == `CTA_RST_TARQ)
        else $error("abort register changed in init mode");
    a_tarq_sw_noclr: assert property (@(posedge aclk) disable iff (!aresetn)
        (tarq_q[0] && !set_empty[0] && !init_mode) |=> tarq_q[0])
        else $error("abort request cleared without empty");
    a_tarq_empty_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(tflg_q[1]) |-> !tarq_q[1])
        else $error("abort request survived empty set");
    a_grant_ack: assert property (@(posedge aclk) disable iff (!aresetn)
        grant[2] |=> tflg_q[2] && taak_q[2])
        else $error("grant did not set empty and ack");
    a_grant_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (grant[0] && tier_q[0]) |=> irqs_q[0])
        else $error("grant did not raise interrupt status");
    a_no_grant_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == CTA_DATA) |-> !grant[cur_q])
        else $error("abort granted during transmission");
    a_ok_no_ack: assert property (@(posedge aclk) disable iff (!aresetn)
        (done_ok[0] && !taak_q[0]) |=> !taak_q[0] && tflg_q[0])
        else $error("success set abort ack");
    a_irq_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        (set_empty[1] && !tier_q[1] && !irqs_q[1]) |=> !irqs_q[1])
        else $error("status set with enable clear");
endmodule // cta_tx_abort
`default_nettype wire

// file: bench/cta_can_node.sv
// far-side bus node: wired-and bus, optional dominant jam, id capture
// assumes the same bit time as the design and a frame opened by a falling edge
`timescale 1ns/1ps
`default_nettype none
module cta_can_node #(
    parameter int BIT_CYC = 4
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low active
    input wire logic can_tx, // design transmit pin
    input wire logic jam, // hold the bus dominant
    output logic can_rx, // resolved bus level
    output logic [28:0] got_id, // captured identifier
    output logic [7:0] frames // captured frame count
);
    logic tx_q;
    logic on_q;
    logic [5:0] nb_q;
    logic [15:0] cnt_q;
    // dominant zero overrides, released bus floats recessive
    assign can_rx = can_tx & ~jam;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_q <= 1'b1;
            on_q <= 1'b0;
            nb_q <= 6'h0;
            cnt_q <= 16'h0;
            got_id <= 29'h0;
            frames <= 8'h0;
        end else begin
            tx_q <= can_tx;
            if (!on_q) begin
                if (tx_q && !can_tx) begin
                    on_q <= 1'b1;
                    cnt_q <= 16'h1;
                    nb_q <= 6'h0;
                end
            end else begin
                cnt_q <= (cnt_q == 16'(BIT_CYC - 1)) ? 16'h0 : cnt_q + 16'h1;
                if (cnt_q == 16'(BIT_CYC / 2)) begin
                    got_id <= {got_id[27:0], can_tx};
                    nb_q <= nb_q + 6'h1;
                    if (nb_q == 6'd28) begin
                        on_q <= 1'b0;
                        frames <= frames + 8'h1;
                    end
                end
            end
        end
    end
endmodule // cta_can_node
`default_nettype wire

// file: bench/cta_tx_abort_tb_top.sv
// self-checking bench: reset-value table, then abort, init and id tests
// assumes the design's axi4-lite slave and cta_can_node as bus partner
`timescale 1ns/1ps
`default_nettype none
module cta_tx_abort_tb_top import cta_pkg::*;;
    localparam int BC = 4;
    localparam int NR = 10;
    localparam logic [28:0] ID0 = 29'h0a5c3e1b;
    localparam logic [28:0] IDX = (ID0 & ~(29'hff << 7)) | (29'h5a << 7);
    localparam logic [7:0] TA [NR] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24, 8'h28,
        8'h2c, 8'h30, 8'h04};
    localparam logic [31:0] TD [NR] = '{32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0};
    localparam logic [1:0] TR [NR] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h2};
    logic aclk, aresetn, can_rx, can_tx, irq, jam;
    logic [7:0] s_axi_awaddr, s_axi_araddr, frames, f0;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [28:0] got_id;
    int fails, samples_checked, cycles, n;
    cta_tx_abort #(.BIT_CYC(BC)) u_cta_tx_abort (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .can_rx, .can_tx, .irq);
    cta_can_node #(.BIT_CYC(BC)) u_cta_can_node (.aclk, .aresetn, .can_tx, .jam, .can_rx,
        .got_id, .frames);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic stop_test();
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // both channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        aw = 1'b0;
        w = 1'b0;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
            if (s_axi_wvalid && s_axi_wready) w = 1'b1;
            if (s_axi_bvalid === 1'b1) b = 1'b1;
            if (b) chk({30'h0, er}, {30'h0, s_axi_bresp});
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, b;
        ar = 1'b0;
        b = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            if (s_axi_arvalid && s_axi_arready) ar = 1'b1;
            if (s_axi_rvalid === 1'b1) b = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (b) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rdr(a, d, r);
        chk(e, d);
        chk({30'h0, er}, {30'h0, r});
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] d;
        logic [1:0] r;
        int k;
        k = 0;
        do begin
            rdr(a, d, r);
            k++;
        end while (((d & m) !== v) && k < 200);
        chk(v, d & m);
    endtask
    task automatic rst();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic run_table();
        for (int i = 0; i < NR; i++) begin
            rd(TA[i], TD[i], TR[i]);
        end
    endtask
    initial begin
        aresetn = 1'b0;
        jam = 1'b0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        rst();
        run_table();
        wr(8'h40, 32'h1, 2'h2);
        // queued-buffer abort with partial enables
        wr(8'h0c, 32'h5, 2'h0);
        wr(8'h2c, 32'h7, 2'h0);
        wr(8'h08, 32'hff, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        wr(8'h14, 32'h7, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        wr(8'h08, 32'hff, 2'h0);
        repeat (3) @(posedge aclk);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h14, 32'h7, 2'h0);
        rd(8'h18, 32'h7, 2'h0);
        rd(8'h24, 32'h5, 2'h0);
        chk(32'h1, {31'h0, irq});
        wr(8'h2c, 32'h0, 2'h0);
        chk(32'h0, {31'h0, irq});
        wr(8'h2c, 32'h7, 2'h0);
        wr(8'h28, 32'h7, 2'h0);
        rd(8'h24, 32'h0, 2'h0);
        chk(32'h0, {31'h0, irq});
        // init mode holds enable and abort registers
        wr(8'h10, 32'h1, 2'h0);
        poll(8'h10, 32'h2, 32'h2);
        rd(8'h0c, 32'h0, 2'h0);
        wr(8'h0c, 32'h7, 2'h0);
        rd(8'h0c, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        wr(8'h10, 32'h0, 2'h0);
        poll(8'h10, 32'h2, 32'h0);
        wr(8'h0c, 32'h7, 2'h0);
        rd(8'h0c, 32'h7, 2'h0);
        // identifier layout and msb-first send, success path
        wr(8'h20, {3'h0, ID0}, 2'h0);
        wr(8'h1c, 32'h5a, 2'h0);
        rd(8'h1c, 32'h5a, 2'h0);
        rd(8'h20, {3'h0, IDX}, 2'h0);
        f0 = frames;
        wr(8'h14, 32'h1, 2'h0);
        rd(8'h18, 32'h6, 2'h0);
        wr(8'h30, 32'h1, 2'h0);
        n = 0;
        while (frames === f0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        chk({3'h0, IDX}, {3'h0, got_id});
        poll(8'h14, 32'h1, 32'h1);
        rd(8'h18, 32'h6, 2'h0);
        rd(8'h24, 32'h1, 2'h0);
        chk(32'h1, {31'h0, irq});
        wr(8'h28, 32'h7, 2'h0);
        // abort during a winning transmission is refused
        wr(8'h14, 32'h1, 2'h0);
        repeat (20) @(posedge aclk);
        wr(8'h08, 32'h1, 2'h0);
        rd(8'h08, 32'h1, 2'h0);
        poll(8'h14, 32'h1, 32'h1);
        rd(8'h18, 32'h6, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        wr(8'h28, 32'h7, 2'h0);
        // lower identifier on the bus wins, abort after lost arbitration
        repeat (150) @(posedge aclk);
        jam <= 1'b1;
        wr(8'h14, 32'h1, 2'h0);
        repeat (40) @(posedge aclk);
        wr(8'h08, 32'h1, 2'h0);
        poll(8'h14, 32'h1, 32'h1);
        rd(8'h14, 32'h7, 2'h0);
        rd(8'h18, 32'h7, 2'h0);
        rd(8'h24, 32'h1, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        jam <= 1'b0;
        rst();
        run_table();
        stop_test();
    end
endmodule // cta_tx_abort_tb_top
`default_nettype wire
